// ===== mcr_register_bank.sv
/*
 * Serial register bank of a brushed DC motor speed controller: frame
 * decoding, readback and tuning registers, lock and save selection, and
 * the output voltage demand built from them.
 * Assumes bytes arrive already deserialised from the UART, replies leave
 * through a byte handshake, and the flash engine lies outside.
 */
// Summary of operation
// - Read 0x11 returns raw speed input
// - Speed input drives demand unless locked
// - Read 0x12 returns load current
// - Read 0x14 returns input period
// - Read 0x15 returns captured pulse width
// - Compensation times current adds to demand
// - Ceiling register caps output demand
// - Supply scaling only when enable set
// - Zero ceiling gives zero output
// - Low/high levels map to 0/100%
// - Status bit9 forward, bit4 brake mode
// - Status bit6 shows brake pin level
// - Bit1 overvoltage, bit0 undervoltage
// - Status bit2 is overheat flag
// - Lock bits block knob updates
// - Lock bits 3..0 speed..acceleration
// - Lock register clears on restart
// - Save select write only marks registers
// - Save select bit map per register
// - Saved knob registers (save bits 0,2,3,4) become locked
// - Write frame: address, command, two data, checksum; read frame: address, command
// - Flash save stops PWM and commands
`timescale 1ns/1ps

module mcr_register_bank #(
	parameter int TICK = mcr_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [6:0] unit_address,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic [11:0] speed_adc,
	input wire logic [11:0] serial_speed,
	input wire logic [11:0] load_current,
	input wire logic pwm_brake_in,
	input wire mcr_pkg::mcr_flags_t flags,
	input wire mcr_pkg::mcr_supply_t supply,
	input wire logic supply_comp_enable,
	input wire logic flash_busy,
	input wire logic save_done,
	output logic [3:0] knob_override_lock,
	output logic [13:0] flash_save_select_first,
	output logic [11:0] voltage_demand,
	output logic pwm_enable
);
	typedef struct packed {
		mcr_pkg::mcr_phase_t phase;
		logic [6:0] cmd;
		logic [6:0] data_hi;
		logic [6:0] data_lo;
		logic [13:0] tx_word;
		logic [6:0] tx_sum;
		logic [13:0] load_drop_compensation;
		logic [11:0] output_voltage_ceiling;
		logic [11:0] speed_input_low_level;
		logic [11:0] speed_input_high_level;
		logic [3:0] lock;
		logic [13:0] save_sel;
		logic [9:0] controller_state_word;
		logic [11:0] demand;
		logic pwm_en;
	} mcr_state_t;

	mcr_state_t state_ff;
	mcr_state_t nxt_state;
	mcr_pkg::mcr_capture_t capture;
	// Kept apart from the state struct: it runs on the raw reset, the struct on the released one
	logic [1:0] rst_sync_ff;
	logic rst_n;

	// ==========================================================
	// Reset release
	// Async assert, sync release through two flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	mcr_pulse_capture #(
		.TICK(TICK)
	) u_capture (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pulse_in(pwm_brake_in),
		.capture(capture)
	);

	// ==========================================================
	// Readback multiplexer
	function automatic logic [14:0] read_word(input logic [6:0] cmd, input mcr_state_t s,
			input mcr_pkg::mcr_capture_t c, input logic [11:0] adc, input logic [11:0] cur);
		logic [14:0] w;
		w = {1'b1, 14'h0000};
		unique case (cmd)
			mcr_pkg::RD_SPEED_IN: w[13:0] = {2'b00, adc};
			mcr_pkg::RD_LOAD_CUR: w[13:0] = {2'b00, cur};
			mcr_pkg::RD_PERIOD: w[13:0] = c.period;
			mcr_pkg::RD_WIDTH: w[13:0] = c.width;
			mcr_pkg::RD_DROP_COMP: w[13:0] = s.load_drop_compensation;
			mcr_pkg::RD_CEILING: w[13:0] = {2'b00, s.output_voltage_ceiling};
			mcr_pkg::RD_LOW_LEVEL: w[13:0] = {2'b00, s.speed_input_low_level};
			mcr_pkg::RD_HIGH_LEVEL: w[13:0] = {2'b00, s.speed_input_high_level};
			mcr_pkg::RD_STATE_WORD: w[13:0] = {4'h0, s.controller_state_word};
			mcr_pkg::RD_LOCK: w[13:0] = {10'h000, s.lock};
			mcr_pkg::RD_SAVE_SEL: w[13:0] = s.save_sel;
			default: w = '0;
		endcase
		return w;
	endfunction

	// ==========================================================
	// Demand path
	logic [11:0] base_level;
	logic [11:0] clamped;
	logic [11:0] span;
	logic [23:0] scaled;
	logic [11:0] mapped;
	logic [25:0] drop_prod;
	logic [14:0] summed_wide;
	logic [13:0] summed;
	logic [25:0] comp_prod;
	logic [13:0] supplied;
	logic [11:0] capped;

	always_comb begin
		// Serial speed takes over once the velocity lock is set
		base_level = state_ff.lock[mcr_pkg::LK_VELOCITY] ? serial_speed : speed_adc;
		clamped = base_level;
		if (clamped < state_ff.speed_input_low_level) begin
			clamped = state_ff.speed_input_low_level;
		end
		if (clamped > state_ff.speed_input_high_level) begin
			clamped = state_ff.speed_input_high_level;
		end
		span = state_ff.speed_input_high_level - state_ff.speed_input_low_level;
		scaled = 24'(clamped - state_ff.speed_input_low_level) * 24'(mcr_pkg::FULL_SCALE);
		// A collapsed span would divide by zero, so the raw level passes
		if (span == 12'h000) begin
			mapped = base_level;
		end else begin
			mapped = 12'(scaled / 24'(span));
		end
		drop_prod = 26'(state_ff.load_drop_compensation) * 26'(load_current);
		summed_wide = 15'(mapped) + 15'(drop_prod >> mcr_pkg::COMP_SHIFT);
		// Saturate so a large compensation never wraps to a low demand
		summed = summed_wide[14] ? 14'h3fff : summed_wide[13:0];
		comp_prod = 26'(summed) * 26'(state_ff.output_voltage_ceiling);
		if (supply_comp_enable) begin
			supplied = 14'(comp_prod >> mcr_pkg::COMP_SHIFT);
		end else begin
			supplied = summed;
		end
		// A zero ceiling yields zero output, as documented
		if (supplied > 14'(state_ff.output_voltage_ceiling)) begin
			capped = state_ff.output_voltage_ceiling;
		end else begin
			capped = supplied[11:0];
		end
	end

	// ==========================================================
	// Frame engine and registers
	logic [14:0] rd;
	logic [6:0] sum;
	logic is_addr;
	logic own_addr;

	always_comb begin
		nxt_state = state_ff;
		rd = read_word(state_ff.cmd, state_ff, capture, speed_adc, load_current);
		sum = 7'(state_ff.cmd + state_ff.data_hi + state_ff.data_lo) & mcr_pkg::BYTE_MASK;
		is_addr = rx_data[mcr_pkg::ADDR_MARK_BIT];
		// An own address in mid frame restarts, so the new frame is not lost
		own_addr = is_addr && rx_data[6:0] == unit_address;

		nxt_state.controller_state_word = '0;
		nxt_state.controller_state_word[mcr_pkg::ST_FORWARD] = flags.forward_run_flag;
		nxt_state.controller_state_word[mcr_pkg::ST_DRIVE_BRAKE] =
			flags.drive_or_braking_flag;
		nxt_state.controller_state_word[mcr_pkg::ST_BRAKE_LEVEL] =
			flags.brake_level_flag;
		nxt_state.controller_state_word[mcr_pkg::ST_OVERHEAT] = flags.overheat_flag;
		nxt_state.controller_state_word[mcr_pkg::ST_HIGH_SUPPLY] =
			supply.supply_level > supply.turn_off_max;
		nxt_state.controller_state_word[mcr_pkg::ST_LOW_SUPPLY] =
			supply.supply_level < supply.turn_on_min;

		nxt_state.pwm_en = !flash_busy;
		nxt_state.demand = flash_busy ? 12'h000 : capped;

		// Saving a register locks it against its knob
		if (save_done) begin
			nxt_state.lock[mcr_pkg::LK_VELOCITY] = state_ff.lock[mcr_pkg::LK_VELOCITY] |
				state_ff.save_sel[mcr_pkg::SV_VELOCITY];
			nxt_state.lock[mcr_pkg::LK_AMP_LIMIT] = state_ff.lock[mcr_pkg::LK_AMP_LIMIT] |
				state_ff.save_sel[mcr_pkg::SV_AMP_LIMIT];
			nxt_state.lock[mcr_pkg::LK_REGEN] = state_ff.lock[mcr_pkg::LK_REGEN] |
				state_ff.save_sel[mcr_pkg::SV_REGEN];
			nxt_state.lock[mcr_pkg::LK_RAMP_UP] = state_ff.lock[mcr_pkg::LK_RAMP_UP] |
				state_ff.save_sel[mcr_pkg::SV_RAMP_UP];
		end

		unique case (state_ff.phase)
			mcr_pkg::MCR_IDLE: begin
				// Data bytes never carry the mark, so a foreign frame is skipped whole
				if (rx_valid && !flash_busy && is_addr &&
						rx_data[6:0] == unit_address) begin
					nxt_state.phase = mcr_pkg::MCR_CMD;
				end
			end
			mcr_pkg::MCR_CMD: begin
				if (rx_valid) begin
					nxt_state.cmd = rx_data[6:0];
					if (is_addr) begin
						nxt_state.phase = (rx_data[6:0] == unit_address) ?
							mcr_pkg::MCR_CMD : mcr_pkg::MCR_IDLE;
					end else if (rx_data[6:0] >= mcr_pkg::WRITE_CMD_BASE) begin
						nxt_state.phase = mcr_pkg::MCR_DATA_HI;
					end else begin
						rd = read_word(rx_data[6:0], state_ff, capture, speed_adc,
							load_current);
						nxt_state.tx_word = rd[13:0];
						nxt_state.tx_sum = 7'(rx_data[6:0] + rd[13:7] + rd[6:0]) &
							mcr_pkg::BYTE_MASK;
						// Unknown read commands get no reply
						nxt_state.phase = (rd[14] && !flash_busy) ?
							mcr_pkg::MCR_TX_HI : mcr_pkg::MCR_IDLE;
					end
				end
			end
			mcr_pkg::MCR_DATA_HI: begin
				if (rx_valid) begin
					nxt_state.data_hi = rx_data[6:0];
					nxt_state.phase = is_addr ?
						(own_addr ? mcr_pkg::MCR_CMD : mcr_pkg::MCR_IDLE) :
						mcr_pkg::MCR_DATA_LO;
				end
			end
			mcr_pkg::MCR_DATA_LO: begin
				if (rx_valid) begin
					nxt_state.data_lo = rx_data[6:0];
					nxt_state.phase = is_addr ?
						(own_addr ? mcr_pkg::MCR_CMD : mcr_pkg::MCR_IDLE) :
						mcr_pkg::MCR_CHECK;
				end
			end
			mcr_pkg::MCR_CHECK: begin
				if (rx_valid) begin
					nxt_state.phase = own_addr ? mcr_pkg::MCR_CMD : mcr_pkg::MCR_IDLE;
					// Bad checksum drops the write silently
					if (!is_addr && rx_data[6:0] == sum && !flash_busy) begin
						unique case (state_ff.cmd)
							mcr_pkg::WR_DROP_COMP: nxt_state.load_drop_compensation =
								{state_ff.data_hi, state_ff.data_lo};
							mcr_pkg::WR_CEILING: nxt_state.output_voltage_ceiling =
								{state_ff.data_hi[4:0], state_ff.data_lo};
							mcr_pkg::WR_LOW_LEVEL: nxt_state.speed_input_low_level =
								{state_ff.data_hi[4:0], state_ff.data_lo};
							mcr_pkg::WR_HIGH_LEVEL: nxt_state.speed_input_high_level =
								{state_ff.data_hi[4:0], state_ff.data_lo};
							// Write wins over a save lock arriving the same cycle
							mcr_pkg::WR_LOCK: nxt_state.lock = state_ff.data_lo[3:0];
							mcr_pkg::WR_SAVE_SEL: nxt_state.save_sel =
								{state_ff.data_hi, state_ff.data_lo};
							default: ;
						endcase
					end
				end
			end
			mcr_pkg::MCR_TX_HI: begin
				if (tx_ready) begin
					nxt_state.phase = mcr_pkg::MCR_TX_LO;
				end
			end
			mcr_pkg::MCR_TX_LO: begin
				if (tx_ready) begin
					nxt_state.phase = mcr_pkg::MCR_TX_SUM;
				end
			end
			mcr_pkg::MCR_TX_SUM: begin
				if (tx_ready) begin
					nxt_state.phase = mcr_pkg::MCR_IDLE;
				end
			end
		endcase
	end

	// Lock register returns to zero on every restart; ceiling and high level reset to 0xfff
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff.phase <= mcr_pkg::MCR_IDLE;
			state_ff.cmd <= '0;
			state_ff.data_hi <= '0;
			state_ff.data_lo <= '0;
			state_ff.tx_word <= '0;
			state_ff.tx_sum <= '0;
			state_ff.load_drop_compensation <= mcr_pkg::DROP_COMP_RST;
			state_ff.output_voltage_ceiling <= mcr_pkg::CEILING_RST;
			state_ff.speed_input_low_level <= mcr_pkg::LOW_LEVEL_RST;
			state_ff.speed_input_high_level <= mcr_pkg::HIGH_LEVEL_RST;
			state_ff.lock <= '0;
			state_ff.save_sel <= '0;
			state_ff.controller_state_word <= '0;
			state_ff.demand <= '0;
			state_ff.pwm_en <= 1'b0;
		end else begin
			state_ff.phase <= nxt_state.phase;
			state_ff.cmd <= nxt_state.cmd;
			state_ff.data_hi <= nxt_state.data_hi;
			state_ff.data_lo <= nxt_state.data_lo;
			state_ff.tx_word <= nxt_state.tx_word;
			state_ff.tx_sum <= nxt_state.tx_sum;
			state_ff.load_drop_compensation <= nxt_state.load_drop_compensation;
			state_ff.output_voltage_ceiling <= nxt_state.output_voltage_ceiling;
			state_ff.speed_input_low_level <= nxt_state.speed_input_low_level;
			state_ff.speed_input_high_level <= nxt_state.speed_input_high_level;
			state_ff.lock <= nxt_state.lock;
			state_ff.save_sel <= nxt_state.save_sel;
			state_ff.controller_state_word <= nxt_state.controller_state_word;
			state_ff.demand <= nxt_state.demand;
			state_ff.pwm_en <= nxt_state.pwm_en;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		tx_valid = 1'b0;
		tx_data = 8'h00;
		unique case (state_ff.phase)
			mcr_pkg::MCR_TX_HI: begin
				tx_valid = 1'b1;
				tx_data = {1'b0, state_ff.tx_word[13:7]};
			end
			mcr_pkg::MCR_TX_LO: begin
				tx_valid = 1'b1;
				tx_data = {1'b0, state_ff.tx_word[6:0]};
			end
			mcr_pkg::MCR_TX_SUM: begin
				tx_valid = 1'b1;
				tx_data = {1'b0, state_ff.tx_sum};
			end
			default: ;
		endcase
	end

	assign knob_override_lock = state_ff.lock;
	assign flash_save_select_first = state_ff.save_sel;
	assign voltage_demand = state_ff.demand;
	assign pwm_enable = state_ff.pwm_en;
endmodule

// ===== mcr_pkg.sv
/*
 * Shared constants and carrier types of the motor controller serial register
 * bank, and the pulse capture unit on the shared PWM/brake input.
 * Assumes one 125 MHz clock, a synchronised active-low reset, and inputs
 * that are already synchronous to that clock.
 */
`timescale 1ns/1ps

package mcr_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Frame layout
	localparam logic [7:0] ADDR_MARK = 8'h80;
	localparam logic [6:0] BYTE_MASK = 7'h7f;
	localparam int ADDR_MARK_BIT = 7;
	localparam logic [6:0] WRITE_CMD_BASE = 7'h40;

	// ==========================================================
	// Read commands
	localparam logic [6:0] RD_SPEED_IN = 7'h11;
	localparam logic [6:0] RD_LOAD_CUR = 7'h12;
	localparam logic [6:0] RD_PERIOD = 7'h14;
	localparam logic [6:0] RD_WIDTH = 7'h15;
	localparam logic [6:0] RD_DROP_COMP = 7'h20;
	localparam logic [6:0] RD_CEILING = 7'h21;
	localparam logic [6:0] RD_LOW_LEVEL = 7'h22;
	localparam logic [6:0] RD_HIGH_LEVEL = 7'h23;
	localparam logic [6:0] RD_STATE_WORD = 7'h30;
	localparam logic [6:0] RD_LOCK = 7'h31;
	localparam logic [6:0] RD_SAVE_SEL = 7'h32;

	// ==========================================================
	// Write commands
	localparam logic [6:0] WR_DROP_COMP = 7'h60;
	localparam logic [6:0] WR_CEILING = 7'h61;
	localparam logic [6:0] WR_LOW_LEVEL = 7'h62;
	localparam logic [6:0] WR_HIGH_LEVEL = 7'h63;
	localparam logic [6:0] WR_LOCK = 7'h71;
	localparam logic [6:0] WR_SAVE_SEL = 7'h72;

	// ==========================================================
	// Status word bits
	localparam int ST_LOW_SUPPLY = 0;
	localparam int ST_HIGH_SUPPLY = 1;
	localparam int ST_OVERHEAT = 2;
	localparam int ST_DRIVE_BRAKE = 4;
	localparam int ST_BRAKE_LEVEL = 6;
	localparam int ST_FORWARD = 9;

	// ==========================================================
	// Lock bits
	localparam int LK_RAMP_UP = 0;
	localparam int LK_REGEN = 1;
	localparam int LK_AMP_LIMIT = 2;
	localparam int LK_VELOCITY = 3;

	// ==========================================================
	// Save selection bits
	localparam int SV_VELOCITY = 0;
	localparam int SV_AMP_LIMIT = 2;
	localparam int SV_REGEN = 3;
	localparam int SV_RAMP_UP = 4;

	// ==========================================================
	// Reset values and arithmetic
	localparam logic [13:0] DROP_COMP_RST = 14'h0000;
	localparam logic [11:0] CEILING_RST = 12'hfff;
	localparam logic [11:0] LOW_LEVEL_RST = 12'h000;
	localparam logic [11:0] HIGH_LEVEL_RST = 12'hfff;
	localparam logic [11:0] FULL_SCALE = 12'hfff;
	localparam int COMP_SHIFT = 12;

	typedef enum logic [2:0] {
		MCR_IDLE = 3'b000,
		MCR_CMD = 3'b001,
		MCR_DATA_HI = 3'b010,
		MCR_DATA_LO = 3'b011,
		MCR_CHECK = 3'b100,
		MCR_TX_HI = 3'b101,
		MCR_TX_LO = 3'b110,
		MCR_TX_SUM = 3'b111
	} mcr_phase_t;

	typedef struct packed {
		logic forward_run_flag;
		logic drive_or_braking_flag;
		logic overheat_flag;
		logic brake_level_flag;
	} mcr_flags_t;

	typedef struct packed {
		logic [11:0] supply_level;
		logic [11:0] turn_off_max;
		logic [11:0] turn_on_min;
	} mcr_supply_t;

	typedef struct packed {
		logic [13:0] period;
		logic [13:0] width;
	} mcr_capture_t;
endpackage

module mcr_pulse_capture #(
	parameter int TICK = mcr_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pulse_in,
	output mcr_pkg::mcr_capture_t capture
);
	typedef struct packed {
		logic prev;
		logic [7:0] tick_cnt;
		logic [13:0] per_cnt;
		logic [13:0] hi_cnt;
		mcr_pkg::mcr_capture_t cap;
	} mcr_cap_state_t;

	mcr_cap_state_t state_ff;
	mcr_cap_state_t nxt_state;
	logic tick;

	// ==========================================================
	// Counting in 1 us steps keeps 14 bits useful down to slow inputs
	always_comb begin
		nxt_state = state_ff;
		tick = (state_ff.tick_cnt == 8'(TICK - 1));
		nxt_state.prev = pulse_in;
		nxt_state.tick_cnt = tick ? 8'h00 : state_ff.tick_cnt + 8'h01;
		if (tick && state_ff.per_cnt != 14'h3fff) begin
			nxt_state.per_cnt = state_ff.per_cnt + 14'h0001;
		end
		if (tick && pulse_in && state_ff.hi_cnt != 14'h3fff) begin
			nxt_state.hi_cnt = state_ff.hi_cnt + 14'h0001;
		end
		if (pulse_in && !state_ff.prev) begin
			nxt_state.cap.period = state_ff.per_cnt;
			nxt_state.per_cnt = 14'h0000;
			nxt_state.hi_cnt = 14'h0000;
		end
		if (!pulse_in && state_ff.prev) begin
			nxt_state.cap.width = state_ff.hi_cnt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign capture = state_ff.cap;
endmodule

// ===== mcr_register_bank_checker.sv
/* Port checker for the serial register bank.
 * Assumes it is bound onto mcr_register_bank, one clock domain. */
`timescale 1ns/1ps
// ====
// Checker
module mcr_register_bank_checker (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [6:0] unit_address,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic flash_busy,
	input wire logic save_done,
	input wire logic [3:0] knob_override_lock,
	input wire logic [13:0] flash_save_select_first,
	input wire logic [11:0] voltage_demand,
	input wire logic pwm_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_foreign;
		rx_valid && rx_data[7] && rx_data[6:0] != unit_address && !tx_valid;
	endsequence
	sequence s_own_read;
		rx_valid && rx_data == {1'b1, unit_address} && !tx_valid && !flash_busy
		##1 rx_valid && rx_data == {1'b0, mcr_pkg::RD_STATE_WORD} && !flash_busy;
	endsequence
	chk_busy_pwm: assert property (flash_busy |=> !pwm_enable)
		else $error("pwm enabled during save");
	chk_busy_demand: assert property (flash_busy |=> voltage_demand == 12'h000)
		else $error("demand not zero during save");
	chk_busy_reply: assert property ($rose(tx_valid) |-> !$past(flash_busy))
		else $error("reply to a command taken during save");
	chk_reply_cause: assert property ($rose(tx_valid) |-> $past(rx_valid))
		else $error("reply without a command byte");
	chk_byte_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte dropped before acceptance");
	chk_foreign_quiet: assert property (s_foreign |=> !tx_valid [*2])
		else $error("reply to a foreign address");
	chk_status_reply: assert property (s_own_read |=> tx_valid)
		else $error("status read not answered");
	chk_lock_holds: assert property (!rx_valid && !save_done |=> $stable(knob_override_lock))
		else $error("lock changed without a cause");
	chk_sel_holds: assert property (!rx_valid |=> $stable(flash_save_select_first))
		else $error("save selection changed without a write");
	chk_save_locks: assert property (save_done && flash_save_select_first[0] && !rx_valid
		|=> knob_override_lock[3])
		else $error("saved speed not locked");
endmodule

bind mcr_register_bank mcr_register_bank_checker chk_i (
	.sys_clk(sys_clk), .rstn(rstn), .unit_address(unit_address), .rx_valid(rx_valid),
	.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.flash_busy(flash_busy), .save_done(save_done), .knob_override_lock(knob_override_lock),
	.flash_save_select_first(flash_save_select_first), .voltage_demand(voltage_demand),
	.pwm_enable(pwm_enable)
);

// ===== mcr_host_model.sv
/* Host model of the register link: frames commands and collects replies.
 * Assumes the bench calls its tasks and sets slow to stall reply bytes. */
`timescale 1ns/1ps
// ====
// Host side
module mcr_host_model (
	input wire logic sys_clk,
	input wire logic [6:0] unit_address,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end
	// Bytes leave back to back, first byte in the top slot
	task automatic put(input logic [39:0] f, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_data <= f[i*8 +: 8];
			rx_valid <= 1'b1;
			@(posedge sys_clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~f[7:0]; // Idle line never repeats the last byte
	endtask
	task automatic wr(input logic [6:0] a, input logic [6:0] c, input logic [13:0] d,
		input logic [6:0] bad);
		logic [6:0] s;
		s = (c + d[13:7] + d[6:0]) ^ bad;
		put({1'b1, a, 1'b0, c, 1'b0, d[13:7], 1'b0, d[6:0], 1'b0, s}, 5);
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [6:0] c, output logic [13:0] d, output logic ok);
		logic [7:0] b[3];
		logic [6:0] s;
		int k;
		put({24'h000000, 1'b1, unit_address, 1'b0, c}, 2);
		for (int i = 0; i < 3; i++) begin
			if (slow) begin
				tx_ready <= 1'b0;
				repeat (3) @(posedge sys_clk);
				tx_ready <= 1'b1;
			end
			k = 0;
			do begin
				@(posedge sys_clk);
				k++;
			end while (tx_valid !== 1'b1 && k < 40);
			b[i] = tx_data;
		end
		d = {b[0][6:0], b[1][6:0]};
		s = c + b[0][6:0] + b[1][6:0];
		ok = (b[2] === {1'b0, s}) && k < 40;
	endtask
endmodule

// ===== mcr_register_bank_test.sv
/* Self-checking bench of the serial register bank.
 * Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
module mcr_register_bank_test;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [6:0] unit_address = 7'h02;
	logic rx_valid, tx_valid, tx_ready, pwm_enable, ok;
	logic [7:0] rx_data, tx_data;
	logic [11:0] speed_adc = 12'habc;
	logic [11:0] serial_speed = 12'h321;
	logic [11:0] load_current = 12'h123;
	logic pwm_brake_in = 1'b0;
	mcr_pkg::mcr_flags_t flags = 4'h0;
	mcr_pkg::mcr_supply_t supply = 36'h0;
	logic supply_comp_enable = 1'b0;
	logic flash_busy = 1'b0;
	logic save_done = 1'b0;
	logic [3:0] knob_override_lock;
	logic [13:0] flash_save_select_first, v;
	logic [11:0] voltage_demand;
	logic [6:0] rst_cmd[6] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h31, 7'h32};
	logic [13:0] rst_exp[6] = '{14'h0, 14'hfff, 14'h0, 14'hfff, 14'h0, 14'h0};
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	initial forever #4 sys_clk = ~sys_clk;

	// Capture unit runs at TICK 2 so one tick is two cycles
	mcr_register_bank #(.TICK(2)) mcr_register_bank_i (
		.sys_clk(sys_clk), .rstn(rstn), .unit_address(unit_address), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.speed_adc(speed_adc), .serial_speed(serial_speed), .load_current(load_current),
		.pwm_brake_in(pwm_brake_in), .flags(flags), .supply(supply),
		.supply_comp_enable(supply_comp_enable), .flash_busy(flash_busy),
		.save_done(save_done), .knob_override_lock(knob_override_lock),
		.flash_save_select_first(flash_save_select_first),
		.voltage_demand(voltage_demand), .pwm_enable(pwm_enable)
	);
	mcr_host_model mcr_host_model_i (
		.sys_clk(sys_clk), .unit_address(unit_address), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [6:0] c, input logic [13:0] exp);
		mcr_host_model_i.rd(c, v, ok);
		check(16'(v), 16'(exp));
		check(16'(ok), 16'h1);
	endtask
	task automatic wr(input logic [6:0] c, input logic [13:0] d);
		mcr_host_model_i.wr(unit_address, c, d, 7'h00);
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic do_reset;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Ceiling is far above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	// Period 10 ticks, width 4 ticks
	always begin
		repeat (12) @(posedge sys_clk);
		pwm_brake_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pwm_brake_in <= 1'b0;
	end

	initial begin
		do_reset();
		foreach (rst_cmd[i]) rchk(rst_cmd[i], rst_exp[i]);
		check(16'(pwm_enable), 16'h1);
		$display("test reset values done");
		rchk(7'h11, 14'h0abc);
		rchk(7'h12, 14'h0123);
		mcr_host_model_i.rd(7'h14, v, ok);
		check(16'(v >= 14'd9 && v <= 14'd11 && ok), 16'h1);
		mcr_host_model_i.rd(7'h15, v, ok);
		check(16'(v >= 14'd3 && v <= 14'd5 && ok), 16'h1);
		flags <= 4'b1010;
		supply <= {12'h800, 12'h700, 12'h100};
		rchk(7'h30, 14'h0206);
		flags <= 4'b0101;
		supply <= {12'h050, 12'h700, 12'h100};
		rchk(7'h30, 14'h0051);
		$display("test readbacks done");
		check(16'(voltage_demand), 16'h0abc);
		wr(7'h61, 14'h0400);
		rchk(7'h21, 14'h0400);
		settle();
		check(16'(voltage_demand), 16'h0400);
		wr(7'h61, 14'h0000);
		settle();
		check(16'(voltage_demand), 16'h0000);
		wr(7'h61, 14'h0fff);
		wr(7'h71, 14'h0008);
		rchk(7'h31, 14'h0008);
		check(16'(knob_override_lock), 16'h0008);
		check(16'(voltage_demand), 16'h0321);
		wr(7'h60, 14'h1000);
		rchk(7'h20, 14'h1000);
		check(16'(voltage_demand), 16'h0444);
		wr(7'h60, 14'h0000);
		supply_comp_enable <= 1'b1;
		wr(7'h61, 14'h0800);
		settle();
		check(16'(voltage_demand), 16'h0190);
		supply_comp_enable <= 1'b0;
		wr(7'h61, 14'h0fff);
		wr(7'h71, 14'h0000);
		speed_adc <= 12'h200;
		wr(7'h62, 14'h0100);
		wr(7'h63, 14'h0300);
		rchk(7'h22, 14'h0100);
		rchk(7'h23, 14'h0300);
		check(16'(voltage_demand), 16'h07ff);
		$display("test demand done");
		wr(7'h72, 14'h000d);
		rchk(7'h32, 14'h000d);
		check(16'(flash_save_select_first), 16'h000d);
		check(16'(knob_override_lock), 16'h0000);
		save_done <= 1'b1;
		@(posedge sys_clk);
		save_done <= 1'b0;
		settle();
		check(16'(knob_override_lock), 16'h000e);
		$display("test save done");
		mcr_host_model_i.wr(unit_address + 7'h01, 7'h61, 14'h0111, 7'h00);
		rchk(7'h21, 14'h0fff);
		mcr_host_model_i.wr(unit_address, 7'h61, 14'h0111, 7'h01);
		rchk(7'h21, 14'h0fff);
		mcr_host_model_i.slow = 1'b1;
		rchk(7'h21, 14'h0fff);
		mcr_host_model_i.slow = 1'b0;
		flash_busy <= 1'b1;
		settle();
		check(16'(pwm_enable), 16'h0);
		check(16'(voltage_demand), 16'h0);
		wr(7'h61, 14'h0222);
		flash_busy <= 1'b0;
		settle();
		rchk(7'h21, 14'h0fff);
		$display("test refusals done");
		do_reset();
		check(16'(knob_override_lock), 16'h0);
		rchk(7'h31, 14'h0000);
		$display("test restart done");
		finish_test();
	end
endmodule
